//--- rtl/dlri_consts.vh
// Constants for the line rail interface: register map, field positions,
// reset values and bus response codes.
// Assumes inclusion by the rail interface top and nothing else.
`ifndef DLRI_CONSTS_VH
`define DLRI_CONSTS_VH

// Register byte offsets
`define DLRI_OFS_OPMODE        8'h00
`define DLRI_OFS_RAILCFG       8'h04
`define DLRI_OFS_STATUS        8'h08

// Register indices returned by the decode function
`define DLRI_IDX_OPMODE        2'h0
`define DLRI_IDX_RAILCFG       2'h1
`define DLRI_IDX_STATUS        2'h2
`define DLRI_IDX_NONE          2'h3

// Operating mode register fields
`define DLRI_OPMODE_LOCAL_LO   0
`define DLRI_OPMODE_LOCAL_HI   1
`define DLRI_OPMODE_RESET      8'h00

// Rail configuration register fields
`define DLRI_CFG_BIPOLAR       0
`define DLRI_CFG_RX_FALL       1
`define DLRI_CFG_TX_FALL       2
`define DLRI_CFG_TXCLK_REF     3
`define DLRI_CFG_WIDTH         4
`define DLRI_CFG_RESET         4'h0

// Status register fields
`define DLRI_ST_LOCAL          0
`define DLRI_ST_TXCLK_REF      1
`define DLRI_ST_RX_POS         2
`define DLRI_ST_RX_NEG         3
`define DLRI_ST_TX_POLARITY    4
`define DLRI_ST_VIOL_LSB       8
`define DLRI_ST_VIOL_W         8

// Bus responses
`define DLRI_RESP_OKAY         2'h0
`define DLRI_RESP_SLVERR       2'h2

`endif

//--- rtl/dlri_edge_sync.v
// Two-stage synchroniser for a foreign clock and data bits sampled beside it.
// Assumes clk_in and data_in are asynchronous to clk.
`timescale 1ns/10ps

module dlri_edge_sync #(
    parameter W = 1
) (
    // Local clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Foreign inputs
    input  wire         clk_in,
    input  wire [W-1:0] data_in,
    // Synchronised outputs
    output wire         level,
    output wire         rise,
    output wire         fall,
    output wire [W-1:0] data
);

    reg         clk_s1_q;   // First stage, read only by second stage
    reg         clk_s2_q;   // Second stage
    reg         clk_s3_q;   // Edge history
    reg [W-1:0] dat_s1_q;   // First stage of data
    reg [W-1:0] dat_s2_q;   // Second stage of data, aligned with clk_s2_q

    ////////////////////////////////////////////////////////////////////////
    // Synchroniser chain
    always @(posedge clk) begin
        if (!rst_n) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            dat_s1_q <= {W{1'b0}};
            dat_s2_q <= {W{1'b0}};
        end else begin
            clk_s1_q <= clk_in;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            dat_s1_q <= data_in;
            dat_s2_q <= dat_s1_q;
        end
    end

    // Edges seen from the second stage onward only
    assign level = clk_s2_q;
    assign rise  = clk_s2_q & ~clk_s3_q;
    assign fall  = ~clk_s2_q & clk_s3_q;
    assign data  = dat_s2_q;

endmodule // dlri_edge_sync

//--- rtl/dlri_rail_if.v
// Line rail interface of one framer channel: receive and transmit rails to
// an external line interface unit, unipolar or bipolar (AMI), with an
// AXI4-Lite register slave.
// Assumes all line pins are asynchronous to aclk and far slower than it.
`timescale 1ns/10ps
`include "dlri_consts.vh"

module dlri_rail_if (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [7:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    // AXI4-Lite read address
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    input  wire [7:0]  s_axi_araddr,
    // AXI4-Lite read data
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    // Receive line pins
    input  wire        receive_line_clock,
    input  wire        receive_positive_rail,
    input  wire        receive_negative_rail,
    // Transmit line pins
    input  wire        transmit_reference_clock,
    output reg         transmit_line_clock,
    output reg         transmit_positive_rail,
    output reg         transmit_negative_rail,
    // Transmit payload pin
    input  wire        serial_transmit_payload,
    // Received data towards the framer
    output reg         rx_bit_q,
    output reg         rx_neg_q,
    output reg         rx_strobe_q,
    output reg         rx_violation_q
);

    ////////////////////////////////////////////////////////////////////////
    // Register decode shared by the read and write paths
    function [1:0] reg_index;
        input [7:0] addr;
        begin
            case (addr)
                `DLRI_OFS_OPMODE:  reg_index = `DLRI_IDX_OPMODE;
                `DLRI_OFS_RAILCFG: reg_index = `DLRI_IDX_RAILCFG;
                `DLRI_OFS_STATUS:  reg_index = `DLRI_IDX_STATUS;
                default:           reg_index = `DLRI_IDX_NONE;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    reg  [7:0]                opmode_q;      // Operating mode select
    reg  [`DLRI_CFG_WIDTH-1:0] cfg_q;        // Rail and edge settings
    reg  [7:0]                awaddr_q;      // Captured write address
    reg  [7:0]                wdata_q;       // Captured write data, low byte
    reg                       wstrb0_q;      // Low byte lane enabled
    reg  [`DLRI_ST_VIOL_W-1:0] viol_cnt_q;   // Bipolar violation count
    reg                       tx_pend_q;     // Payload bit awaiting launch
    reg                       tx_pol_q;      // Next mark polarity, 1 = neg
    wire                      local_time;    // Transmit timed by reference
    wire                      txclk_ref;     // Transmit clock from reference
    wire                      bipolar;       // Dual rail mode
    wire                      rx_lvl;        // Synced receive clock
    wire                      rx_rise;       // Receive clock rising
    wire                      rx_fall;       // Receive clock falling
    wire [1:0]                rx_rails;      // Synced receive rails
    wire                      ref_lvl;       // Synced reference clock
    wire                      ref_rise;      // Reference clock rising
    wire                      ref_fall;      // Reference clock falling
    wire                      ref_payload;   // Synced payload
    wire                      rx_edge;       // Selected receive edge
    wire                      tx_lvl;        // Selected transmit clock level
    wire                      tx_edge;       // Selected transmit update edge
    wire                      pay_edge;      // Payload sampling edge
    wire                      wr_fire;       // Both write halves held
    wire [31:0]               status_word;   // Live status

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    assign local_time = (opmode_q[1:0] == 2'h1) | opmode_q[`DLRI_OPMODE_LOCAL_HI];
    assign txclk_ref  = local_time | cfg_q[`DLRI_CFG_TXCLK_REF];
    assign bipolar    = cfg_q[`DLRI_CFG_BIPOLAR];

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for the recovered clock with its rails and for the
    // reference clock with the payload
    dlri_edge_sync #(.W(2)) u_rx_sync (
        .clk     (aclk),
        .rst_n   (aresetn),
        .clk_in  (receive_line_clock),
        .data_in ({receive_negative_rail, receive_positive_rail}),
        .level   (rx_lvl),
        .rise    (rx_rise),
        .fall    (rx_fall),
        .data    (rx_rails)
    );

    dlri_edge_sync #(.W(1)) u_ref_sync (
        .clk     (aclk),
        .rst_n   (aresetn),
        .clk_in  (transmit_reference_clock),
        .data_in (serial_transmit_payload),
        .level   (ref_lvl),
        .rise    (ref_rise),
        .fall    (ref_fall),
        .data    (ref_payload)
    );

    // Edge selection
    assign rx_edge  = cfg_q[`DLRI_CFG_RX_FALL] ? rx_fall : rx_rise;
    assign tx_lvl   = txclk_ref ? ref_lvl : rx_lvl;
    assign tx_edge  = cfg_q[`DLRI_CFG_TX_FALL] ? (txclk_ref ? ref_fall : rx_fall)
                                               : (txclk_ref ? ref_rise : rx_rise);
    assign pay_edge = local_time ? ref_rise : rx_rise;

    ////////////////////////////////////////////////////////////////////////
    // Receive path: sample rails on the chosen recovered-clock edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_bit_q       <= 1'b0;
            rx_neg_q       <= 1'b0;
            rx_strobe_q    <= 1'b0;
            rx_violation_q <= 1'b0;
            viol_cnt_q     <= {`DLRI_ST_VIOL_W{1'b0}};
        end else begin
            rx_strobe_q    <= rx_edge;
            rx_violation_q <= 1'b0;
            if (rx_edge) begin
                if (bipolar) begin
                    // Positive rail marks a positive pulse, negative a negative one
                    rx_bit_q <= rx_rails[0] | rx_rails[1];
                    rx_neg_q <= rx_rails[1];
                    if (rx_rails[0] & rx_rails[1]) begin
                        // Both rails at once cannot be a legal pulse
                        rx_violation_q <= 1'b1;
                        viol_cnt_q     <= viol_cnt_q + 8'h01;
                    end
                end else begin
                    // Single rail: positive carries the data
                    rx_bit_q <= rx_rails[0];
                    rx_neg_q <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit path: capture payload, then launch on the update edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_pend_q              <= 1'b0;
            tx_pol_q               <= 1'b0;
            transmit_line_clock    <= 1'b0;
            transmit_positive_rail <= 1'b0;
            transmit_negative_rail <= 1'b0;
        end else begin
            // Line clock follows the selected source
            transmit_line_clock <= tx_lvl;
            if (pay_edge) begin
                tx_pend_q <= ref_payload;
            end
            if (tx_edge) begin
                if (bipolar) begin
                    // Marks alternate polarity; spaces leave both rails low
                    transmit_positive_rail <= tx_pend_q & ~tx_pol_q;
                    transmit_negative_rail <= tx_pend_q & tx_pol_q;
                    if (tx_pend_q) begin
                        tx_pol_q <= ~tx_pol_q;
                    end
                end else begin
                    // Single rail: data on the positive rail only
                    transmit_positive_rail <= tx_pend_q;
                    transmit_negative_rail <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status word
    assign status_word = {16'h0000, viol_cnt_q, 3'h0, tx_pol_q, rx_rails[1], rx_rails[0],
                          txclk_ref, local_time};

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DLRI_RESP_OKAY;
            awaddr_q      <= 8'h00;
            wdata_q       <= 8'h00;
            wstrb0_q      <= 1'b0;
            opmode_q      <= `DLRI_OPMODE_RESET;
            cfg_q         <= `DLRI_CFG_RESET;
        end else begin
            // Hold each half until the response is accepted
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awaddr_q      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_q      <= s_axi_wdata[7:0];
                wstrb0_q     <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                // Perform the write and raise the response
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `DLRI_RESP_OKAY;
                case (reg_index(awaddr_q))
                    `DLRI_IDX_OPMODE: begin
                        if (wstrb0_q) begin
                            opmode_q <= wdata_q;
                        end
                    end
                    `DLRI_IDX_RAILCFG: begin
                        if (wstrb0_q) begin
                            cfg_q <= wdata_q[`DLRI_CFG_WIDTH-1:0];
                        end
                    end
                    `DLRI_IDX_STATUS: begin
                        // Read-only: write ignored
                        s_axi_bresp <= `DLRI_RESP_OKAY;
                    end
                    default: begin
                        // Unmapped address
                        s_axi_bresp <= `DLRI_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                // Response taken: reopen both channels
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel: one cycle from address to data
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `DLRI_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `DLRI_RESP_OKAY;
                case (reg_index(s_axi_araddr))
                    `DLRI_IDX_OPMODE:  s_axi_rdata <= {24'h000000, opmode_q};
                    `DLRI_IDX_RAILCFG: s_axi_rdata <= {28'h0000000, cfg_q};
                    `DLRI_IDX_STATUS:  s_axi_rdata <= status_word;
                    default: begin
                        // Unmapped address reads zero with an error
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `DLRI_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // dlri_rail_if

//--- dv/dlri_lineunit_model.sv
// Line unit model: recovered receive clock, receive rails, reference clock.
// Assumes the bench picks the symbol; clocks run free as on a live line.
`timescale 1ns/10ps
module dlri_lineunit_model #(
    parameter RX_HALF  = 24,
    parameter REF_HALF = 20
) (
    // Symbol: bit1 positive pulse, bit0 negative pulse
    input  wire [1:0] rx_sym,
    // Line pins
    output reg        receive_line_clock,
    output reg        receive_positive_rail,
    output reg        receive_negative_rail,
    output reg        transmit_reference_clock
);
    // Recovered clock, the receive timing reference
    initial begin
        receive_line_clock = 1'b0;
        forever #(RX_HALF) receive_line_clock = ~receive_line_clock;
    end
    // Reference clock, slowed from line rate to suit the core clock
    initial begin
        transmit_reference_clock = 1'b0;
        #7;
        forever #(REF_HALF) transmit_reference_clock = ~transmit_reference_clock;
    end
    // Rails quiet at start
    initial begin
        receive_positive_rail = 1'b0;
        receive_negative_rail = 1'b0;
    end
    // Positive rail only for a positive pulse
    always @(negedge receive_line_clock) begin
        receive_positive_rail <= rx_sym[1];
        receive_negative_rail <= rx_sym[0];
    end
endmodule // dlri_lineunit_model

//--- dv/dlri_rail_monitor.sv
// Port checker of the line rail interface.
// Assumes write address and data are offered in the same cycle.
`timescale 1ns/10ps
module dlri_rail_monitor (
    // Clock, reset and bus
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0]  s_axi_wstrb,
    // Line pins and receive outputs
    input wire        receive_line_clock,
    input wire        transmit_reference_clock,
    input wire        transmit_line_clock,
    input wire        transmit_positive_rail,
    input wire        transmit_negative_rail,
    input wire        rx_bit_q,
    input wire        rx_neg_q,
    input wire        rx_strobe_q,
    input wire        rx_violation_q
);
    reg  [7:0] opm_q;   // Shadow of operating mode
    reg  [3:0] cfg_q;   // Shadow of rail config
    reg  [4:0] quiet_q; // Cycles since last write
    wire       wr_go   = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
    wire       local_w = |opm_q[1:0];
    wire       settled = (quiet_q == 5'h1f);
    // Shadow registers follow accepted writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            opm_q   <= 8'h00;
            cfg_q   <= 4'h0;
            quiet_q <= 5'h00;
        end else begin
            if (wr_go && s_axi_awaddr == 8'h00)
                opm_q <= s_axi_wdata[7:0];
            if (wr_go && s_axi_awaddr == 8'h04)
                cfg_q <= s_axi_wdata[3:0];
            if (wr_go)
                quiet_q <= 5'h00;
            else if (!settled)
                quiet_q <= quiet_q + 5'h01;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    // A change of receive edge may bring two strobes four cycles apart
    chk_strobe_single: assert property (rx_strobe_q |=> !rx_strobe_q [*3])
        else $error("receive strobe too long");
    chk_uni_rx_neg: assert property (settled && !cfg_q[0] && rx_strobe_q |-> !rx_neg_q && !rx_violation_q)
        else $error("negative rail used in unipolar");
    chk_bip_viol: assert property (rx_violation_q |-> rx_strobe_q && rx_bit_q && rx_neg_q)
        else $error("violation without both marks");
    chk_bip_mark: assert property (settled && cfg_q[0] && rx_strobe_q && rx_neg_q |-> rx_bit_q)
        else $error("negative mark not a one");
    chk_rx_edge: assert property (settled && rx_strobe_q |-> $sampled(receive_line_clock) == !cfg_q[1])
        else $error("receive sample on wrong edge");
    chk_tx_pair_excl: assert property (!(transmit_positive_rail && transmit_negative_rail))
        else $error("both transmit rails high");
    chk_uni_tx_neg: assert property (settled && !cfg_q[0] |-> !transmit_negative_rail)
        else $error("negative rail driven in unipolar");
    chk_ref_clock_src: assert property (settled && local_w && $rose(transmit_reference_clock)
        |-> ##[1:6] $rose(transmit_line_clock))
        else $error("line clock not from reference");
    chk_rx_clock_src: assert property (settled && !local_w && !cfg_q[3] && $rose(receive_line_clock)
        |-> ##[1:6] $rose(transmit_line_clock))
        else $error("line clock not from receive clock");
    cov_violation: cover property (rx_violation_q);
    cov_bip_neg: cover property (settled && cfg_q[0] && transmit_negative_rail);
    cov_local: cover property (settled && local_w && $rose(transmit_line_clock));
endmodule // dlri_rail_monitor

bind dlri_rail_if dlri_rail_monitor u_mon (.*);

//--- dv/test_dlri_rail_if.sv
// Bench of the line rail interface: register, receive and transmit tests.
// Assumes the line unit model and the bound checker.
`timescale 1ns/10ps
module test_dlri_rail_if;
    reg         aclk = 1'b0, aresetn = 1'b0, serial_transmit_payload = 1'b0;
    reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg  [3:0]  s_axi_wstrb = 4'h0;
    reg  [1:0]  rx_sym = 2'h0, r, rp;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        receive_line_clock, receive_positive_rail, receive_negative_rail;
    wire        transmit_reference_clock, transmit_line_clock;
    wire        transmit_positive_rail, transmit_negative_rail;
    wire        rx_bit_q, rx_neg_q, rx_strobe_q, rx_violation_q;
    integer     n_mismatch = 0, cmp_count = 0, i, j, c;
    reg  [47:0] tbl = 48'hfcfd03020100;
    always #2.5 aclk = ~aclk;
    dlri_rail_if DUT (.*);
    dlri_lineunit_model u_unit (.*);
    ////////////////////////////////////////////////////////////////////////
    task check(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
            if (n_mismatch == 0 && cmp_count > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // Bounded wait ran out
    task stuck(input integer k, input integer lim);
        begin
            if (k >= lim) begin
                n_mismatch = n_mismatch + 1;
                conclude;
            end
        end
    endtask
    // Write with address and data offered together
    task axi_wr(input [7:0] a, input [31:0] d, input [1:0] er);
        integer k;
        reg     aw, w, b;
        begin
            s_axi_awaddr  <= a;
            s_axi_wdata   <= d;
            s_axi_wstrb   <= 4'hf;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid  <= 1'b1;
            s_axi_bready  <= 1'b1;
            {aw, w, b} = 3'b000;
            k = 0;
            while (!b && k < 64) begin
                @(posedge aclk);
                k = k + 1;
                if (aw && w && s_axi_bvalid === 1'b1) begin
                    b = 1'b1;
                    s_axi_bready <= 1'b0;
                    check({30'h0, s_axi_bresp}, {30'h0, er});
                end
                if (!aw && s_axi_awready === 1'b1) begin
                    aw = 1'b1;
                    s_axi_awvalid <= 1'b0;
                end
                if (!w && s_axi_wready === 1'b1) begin
                    w = 1'b1;
                    s_axi_wvalid <= 1'b0;
                end
            end
            stuck(k, 64);
            @(posedge aclk);
        end
    endtask
    // Read and compare the masked word and response
    task axi_rd(input [7:0] a, input [31:0] e, input [31:0] m, input [1:0] er);
        integer k;
        reg     ar, rd;
        begin
            s_axi_araddr  <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready  <= 1'b1;
            {ar, rd} = 2'b00;
            k = 0;
            while (!rd && k < 64) begin
                @(posedge aclk);
                k = k + 1;
                if (ar && s_axi_rvalid === 1'b1) begin
                    rd = 1'b1;
                    s_axi_rready <= 1'b0;
                    check(s_axi_rdata & m, e);
                    check({30'h0, s_axi_rresp}, {30'h0, er});
                end
                if (!ar && s_axi_arready === 1'b1) begin
                    ar = 1'b1;
                    s_axi_arvalid <= 1'b0;
                end
            end
            stuck(k, 64);
            @(posedge aclk);
        end
    endtask
    // Present a symbol, compare bit, negative mark, violation at third strobe
    task rx_try(input [1:0] s, input [2:0] e);
        integer k, n;
        begin
            rx_sym <= s;
            n = 0;
            k = 0;
            while (n < 3 && k < 200) begin
                @(posedge aclk);
                k = k + 1;
                if (rx_strobe_q === 1'b1)
                    n = n + 1;
            end
            stuck(k, 200);
            check({29'h0, rx_bit_q, rx_neg_q, rx_violation_q}, {29'h0, e});
        end
    endtask
    // Wait n reference rises; sample rails or count line clock rises
    task tx_look(input integer n);
        integer k;
        reg     p, q;
        begin
            k = 0;
            c = 0;
            p = transmit_reference_clock;
            q = transmit_line_clock;
            while (n > 0 && k < 400) begin
                @(posedge aclk);
                k = k + 1;
                if (!p && transmit_reference_clock)
                    n = n - 1;
                if (!q && transmit_line_clock)
                    c = c + 1;
                p = transmit_reference_clock;
                q = transmit_line_clock;
            end
            stuck(k, 400);
            r = {transmit_positive_rail, transmit_negative_rail};
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values, unmapped and read-only places
        axi_rd(8'h00, 32'h0, 32'hffffffff, 2'h0);
        axi_rd(8'h04, 32'h0, 32'hffffffff, 2'h0);
        axi_rd(8'h0c, 32'h0, 32'hffffffff, 2'h2);
        axi_wr(8'h0c, 32'h1, 2'h2);
        axi_wr(8'h08, 32'hff, 2'h0);
        axi_rd(8'h08, 32'h0, 32'h3, 2'h0);
        // Operating mode codes and the local-time flags
        for (i = 0; i < 6; i = i + 1) begin
            axi_wr(8'h00, {24'h0, tbl[8*i +: 8]}, 2'h0);
            axi_rd(8'h00, {24'h0, tbl[8*i +: 8]}, 32'hff, 2'h0);
            axi_rd(8'h08, {30'h0, {2{|tbl[8*i +: 2]}}}, 32'h3, 2'h0);
        end
        // Receive: each rail mode and edge against every symbol
        for (i = 0; i < 4; i = i + 1) begin
            axi_wr(8'h04, i, 2'h0);
            for (j = 0; j < 4; j = j + 1)
                rx_try(j, i[0] ? {|j[1:0], j[0], &j[1:0]} : {j[1], 2'b00});
        end
        // Both rails still high from the last symbol: status shows them
        axi_rd(8'h08, 32'hc, 32'hc, 2'h0);
        rx_sym <= 2'h0;
        // Transmit in local time: unipolar with both edges, then bipolar
        axi_wr(8'h00, 32'h1, 2'h0);
        for (i = 0; i < 3; i = i + 1) begin
            axi_wr(8'h04, (i == 2) ? 32'h1 : 4 * i, 2'h0);
            serial_transmit_payload <= 1'b0;
            tx_look(4);
            check({30'h0, r}, 32'h0);
            serial_transmit_payload <= 1'b1;
            tx_look(4);
            rp = r;
            if (i < 2)
                check({30'h0, r}, 32'h2);
            for (j = 0; j < 4 && i == 2; j = j + 1) begin
                tx_look(1);
                check({30'h0, r}, {30'h0, ~rp});
                check({31'h0, ^r}, 32'h1);
                rp = r;
            end
        end
        // Transmit line clock source: reference, selected reference, receive
        serial_transmit_payload <= 1'b0;
        tx_look(24);
        check({31'h0, (c >= 23 && c <= 25)}, 32'h1);
        axi_wr(8'h00, 32'h0, 2'h0);
        axi_wr(8'h04, 32'h8, 2'h0);
        tx_look(24);
        check({31'h0, (c >= 23 && c <= 25)}, 32'h1);
        axi_wr(8'h04, 32'h0, 2'h0);
        tx_look(24);
        check({31'h0, (c >= 19 && c <= 21)}, 32'h1);
        conclude;
    end
endmodule // test_dlri_rail_if
